/* shared/radio_pkg.sv */
`default_nettype none
package radio_pkg;
    // special-function register addresses
    localparam logic [7:0] CTRL_ADDR = 8'ha0;
    localparam logic [7:0] DATA_ADDR = 8'hb2;
    localparam logic [7:0] ROUTE_ADDR = 8'hb3;
    localparam logic [7:0] DIV_ADDR = 8'hb4;

    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h80;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [1:0] ROUTE_RESET = 2'h0;
    localparam logic [1:0] DIV_RESET = 2'h0;
    localparam logic [7:0] READ_FILL = 8'h00;

    // control port bit positions
    localparam int PWR_BIT = 7;
    localparam int CE_BIT = 6;
    localparam int CS_BIT = 3;
    localparam int CLK_BIT = 1;
    localparam int DAT_BIT = 0;
    localparam int ROUTE_UPPER_BIT = 1;

    // serial timing in cpu clock cycles
    localparam logic [5:0] HALF_BASE = 6'h04;
    localparam logic [5:0] READY_DELAY = 6'h07;
    localparam logic [2:0] LAST_BIT = 3'h7;

    localparam int BYTE_W = 8;
    localparam logic [1:0] FIFO_DEPTH = 2'h2;

    typedef enum logic [1:0] {
        ROUTE_OFF = 2'b00,
        ROUTE_PORT = 2'b01,
        ROUTE_RADIO = 2'b10,
        ROUTE_RESERVED = 2'b11
    } route_t;

    typedef enum logic [2:0] {
        MODE_POWER_DOWN,
        MODE_STANDBY,
        MODE_CONFIG,
        MODE_ACTIVE,
        MODE_ILLEGAL
    } mode_t;

    typedef struct packed {
        logic power_on;
        logic ce;
        logic cs;
        logic shift_clk;
        logic data;
    } radio_lines_t;
endpackage : radio_pkg
`default_nettype wire

/* hdl/serial_shifter.sv */
`timescale 1ns/10ps
`default_nettype none
module serial_shifter (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // request
    input wire logic start,
    input wire logic [7:0] tx_byte,
    input wire logic [1:0] div,
    // serial lines
    input wire logic sdi,
    output logic sck,
    output logic sdo,
    // answer
    output logic idle,
    output logic done,
    output logic [7:0] rx_byte
);
    typedef enum logic [2:0] {S_IDLE, S_LEAD, S_HIGH, S_LOW, S_TAIL} shift_state_t;

    shift_state_t state, next_state;
    logic [5:0] cnt, next_cnt;
    logic [2:0] bitn, next_bitn;
    logic [7:0] sh, next_sh, rx, next_rx;
    logic next_sck, next_sdo, next_done;
    logic [5:0] half;

    // half period: 4, 8, 16 or 32 cycles for ratios 1/8 .. 1/64
    assign half = radio_pkg::HALF_BASE << div;
    assign idle = (state == S_IDLE);
    assign rx_byte = rx;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_bitn = bitn;
        next_sh = sh;
        next_rx = rx;
        next_sck = sck;
        next_sdo = sdo;
        next_done = 1'b0;
        case (state)
            S_IDLE: begin
                if (start) begin
                    next_sh = tx_byte;
                    next_sdo = tx_byte[7];
                    next_sck = 1'b0;
                    next_bitn = 3'h0;
                    next_cnt = half - 6'h01;
                    next_state = S_LEAD;
                end
            end
            S_LEAD, S_LOW: begin
                if (cnt == 6'h00) begin
                    // input sampled on the rising edge
                    next_sck = 1'b1;
                    next_rx = {rx[6:0], sdi};
                    next_cnt = half - 6'h01;
                    next_state = S_HIGH;
                end else begin
                    next_cnt = cnt - 6'h01;
                end
            end
            S_HIGH: begin
                if (cnt == 6'h00) begin
                    next_sck = 1'b0;
                    if (bitn == radio_pkg::LAST_BIT) begin
                        next_cnt = radio_pkg::READY_DELAY - 6'h01;
                        next_state = S_TAIL;
                    end else begin
                        // output shifted on the falling edge, msb first
                        next_sh = {sh[6:0], 1'b0};
                        next_sdo = sh[6];
                        next_bitn = bitn + 3'h1;
                        next_cnt = half - 6'h01;
                        next_state = S_LOW;
                    end
                end else begin
                    next_cnt = cnt - 6'h01;
                end
            end
            S_TAIL: begin
                if (cnt == 6'h00) begin
                    next_done = 1'b1;
                    next_state = S_IDLE;
                end else begin
                    next_cnt = cnt - 6'h01;
                end
            end
            default: next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= S_IDLE;
            cnt <= 6'h00;
            bitn <= 3'h0;
            sh <= 8'h00;
            rx <= radio_pkg::DATA_RESET;
            sck <= 1'b0;
            sdo <= 1'b0;
            done <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            bitn <= next_bitn;
            sh <= next_sh;
            rx <= next_rx;
            sck <= next_sck;
            sdo <= next_sdo;
            done <= next_done;
        end
    end
endmodule : serial_shifter
`default_nettype wire

/* hdl/radio_control_port.sv */
// Overview of operation
// - control port is an 8-bit register at a0 hex, reset value 80 hex
// - control port is write-only; reads give no meaningful value
// - bit7 power-up, bit6 transmit enable, bit3 config select, bit1 clock, bit0 data
// - route 00 unused, 01 general port pins, 10 transmitter, 11 reserved
// - route upper bit 0: every radio line follows its port bit directly
// - route 10: shift clock from serial clock, data from serial out, input unused
// - during reset: config select 0, transmit enable 0, power-up 1
// - after reset, outputs hold defaults until software writes the port
// - mode decode: 110 active, 101 config, 100 standby, 0xx power down
// - only burst transmit mode is used; streaming transmit unsupported
// - port is output-only toward the transmitter, never bidirectional
// - lowering transmit enable after loading triggers the burst
// - burst: rf up, preamble, crc, send at configured rate, back to standby
// - each serial data write accepted while the buffer has room shifts 8 bits out msb first, 8 bits in
// - serial clock is cpu clock divided by 8, 16, 32 or 64
// - after eighth serial clock the done flag sets; software clears it
// - config word up to 18 bits shifted while config select high
`timescale 1ns/10ps
`default_nettype none
module radio_control_port (
    // clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // special-function register port
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    input wire logic [7:0] SFR_WDATA,
    output logic [7:0] SFR_RDATA,
    // serial done flag and write buffer state
    output logic SERIAL_DONE,
    input wire logic SERIAL_DONE_CLR,
    output logic TX_READY,
    // transmitter control lines
    output logic RADIO_POWER_ON,
    output logic RADIO_CE,
    output logic RADIO_CS,
    output logic RADIO_SHIFT_CLK,
    output logic RADIO_DATA,
    output logic [2:0] RADIO_MODE,
    output logic BURST_START,
    // general port serial pins
    output logic P1_SCK,
    output logic P1_SDO,
    input wire logic P1_SDI
);
    // register file
    logic [7:0] ctrl, next_ctrl;
    logic [1:0] route, next_route;
    logic [1:0] div, next_div;
    logic [7:0] rdata, next_rdata;
    logic done_flag, next_done_flag;

    // write buffer
    logic [7:0] buf_mem [0:1];
    logic [7:0] next_buf_mem [0:1];
    logic wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
    logic [1:0] count, next_count;
    logic push, pop, buf_ready;

    // serial engine
    logic sh_sck, sh_sdo, sh_idle, sh_done;
    logic [7:0] sh_rx;
    logic sdi_meta, sdi_sync, sh_sdi;

    // registered outputs
    radio_pkg::radio_lines_t lines, next_lines;
    logic [2:0] mode, next_mode;
    logic burst, next_burst;
    logic p1_sck, p1_sdo, next_p1_sck, next_p1_sdo;
    logic tx_ready, next_tx_ready;

    // pin input: two flops before any use
    always_ff @(posedge MCLK) begin
        if (RST) begin
            sdi_meta <= 1'b0;
            sdi_sync <= 1'b0;
        end else begin
            sdi_meta <= P1_SDI;
            sdi_sync <= sdi_meta;
        end
    end

    // input line is left unused while routed to the transmitter
    assign sh_sdi = (route == radio_pkg::ROUTE_PORT) ? sdi_sync : 1'b0;

    // a queued byte starts only once software has cleared the previous done flag
    assign buf_ready = (count != radio_pkg::FIFO_DEPTH);
    assign push = SFR_WR && (SFR_ADDR == radio_pkg::DATA_ADDR) && buf_ready;
    assign pop = (count != 2'h0) && sh_idle && !done_flag && !sh_done
        && (route != radio_pkg::ROUTE_OFF);

    serial_shifter u_shifter (
        .clk(MCLK),
        .rst(RST),
        .start(pop),
        .tx_byte(buf_mem[rd_ptr]),
        .div(div),
        .sdi(sh_sdi),
        .sck(sh_sck),
        .sdo(sh_sdo),
        .idle(sh_idle),
        .done(sh_done),
        .rx_byte(sh_rx)
    );

    // register writes and reads
    always_comb begin
        next_ctrl = ctrl;
        next_route = route;
        next_div = div;
        next_rdata = rdata;
        if (SFR_WR) begin
            case (SFR_ADDR)
                radio_pkg::CTRL_ADDR: next_ctrl = SFR_WDATA;
                radio_pkg::ROUTE_ADDR: next_route = SFR_WDATA[1:0];
                radio_pkg::DIV_ADDR: next_div = SFR_WDATA[1:0];
                default: next_ctrl = ctrl;
            endcase
        end
        if (SFR_RD) begin
            case (SFR_ADDR)
                // write-only port: reads carry no information
                radio_pkg::CTRL_ADDR: next_rdata = radio_pkg::READ_FILL;
                radio_pkg::DATA_ADDR: next_rdata = sh_rx;
                radio_pkg::ROUTE_ADDR: next_rdata = {6'h00, route};
                radio_pkg::DIV_ADDR: next_rdata = {6'h00, div};
                default: next_rdata = radio_pkg::READ_FILL;
            endcase
        end
        // hardware set beats a simultaneous software clear
        next_done_flag = sh_done | (done_flag & ~SERIAL_DONE_CLR);
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            ctrl <= radio_pkg::CTRL_RESET;
            route <= radio_pkg::ROUTE_RESET;
            div <= radio_pkg::DIV_RESET;
            rdata <= radio_pkg::READ_FILL;
            done_flag <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            route <= next_route;
            div <= next_div;
            rdata <= next_rdata;
            done_flag <= next_done_flag;
        end
    end

    // two-entry write buffer
    always_comb begin
        next_buf_mem[0] = buf_mem[0];
        next_buf_mem[1] = buf_mem[1];
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        if (push) begin
            next_buf_mem[wr_ptr] = SFR_WDATA;
            next_wr_ptr = ~wr_ptr;
        end
        if (pop) begin
            next_rd_ptr = ~rd_ptr;
        end
        if (push && !pop) begin
            next_count = count + 2'h1;
        end else if (pop && !push) begin
            next_count = count - 2'h1;
        end
        next_tx_ready = (next_count != radio_pkg::FIFO_DEPTH);
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            buf_mem[0] <= 8'h00;
            buf_mem[1] <= 8'h00;
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
            tx_ready <= 1'b1;
        end else begin
            buf_mem[0] <= next_buf_mem[0];
            buf_mem[1] <= next_buf_mem[1];
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            tx_ready <= next_tx_ready;
        end
    end

    // radio line routing and mode decode, all from one set of flops
    always_comb begin
        next_lines.power_on = next_ctrl[radio_pkg::PWR_BIT];
        next_lines.ce = next_ctrl[radio_pkg::CE_BIT];
        next_lines.cs = next_ctrl[radio_pkg::CS_BIT];
        next_lines.shift_clk = next_ctrl[radio_pkg::CLK_BIT];
        next_lines.data = next_ctrl[radio_pkg::DAT_BIT];
        if (next_route == radio_pkg::ROUTE_RADIO) begin
            next_lines.shift_clk = sh_sck;
            next_lines.data = sh_sdo;
        end
        next_p1_sck = (next_route == radio_pkg::ROUTE_PORT) ? sh_sck : 1'b0;
        next_p1_sdo = (next_route == radio_pkg::ROUTE_PORT) ? sh_sdo : 1'b0;
        case ({next_lines.power_on, next_lines.ce, next_lines.cs})
            3'b110: next_mode = radio_pkg::MODE_ACTIVE;
            3'b101: next_mode = radio_pkg::MODE_CONFIG;
            3'b100: next_mode = radio_pkg::MODE_STANDBY;
            3'b111: next_mode = radio_pkg::MODE_ILLEGAL;
            default: next_mode = radio_pkg::MODE_POWER_DOWN;
        endcase
        // falling transmit enable while powered launches the loaded packet
        next_burst = lines.ce && !next_lines.ce && next_lines.power_on
            && !next_lines.cs;
    end

    // reset is synchronous: defaults appear on the first edge with reset high
    always_ff @(posedge MCLK) begin
        if (RST) begin
            lines <= '{power_on: 1'b1, ce: 1'b0, cs: 1'b0, shift_clk: 1'b0, data: 1'b0};
            mode <= radio_pkg::MODE_STANDBY;
            burst <= 1'b0;
            p1_sck <= 1'b0;
            p1_sdo <= 1'b0;
        end else begin
            lines <= next_lines;
            mode <= next_mode;
            burst <= next_burst;
            p1_sck <= next_p1_sck;
            p1_sdo <= next_p1_sdo;
        end
    end

    // output-only toward the transmitter: no enables, no read-back of pins
    assign RADIO_POWER_ON = lines.power_on;
    assign RADIO_CE = lines.ce;
    assign RADIO_CS = lines.cs;
    assign RADIO_SHIFT_CLK = lines.shift_clk;
    assign RADIO_DATA = lines.data;
    assign RADIO_MODE = mode;
    assign BURST_START = burst;
    assign P1_SCK = p1_sck;
    assign P1_SDO = p1_sdo;
    assign SFR_RDATA = rdata;
    assign SERIAL_DONE = done_flag;
    assign TX_READY = tx_ready;
endmodule : radio_control_port
`default_nettype wire

/* sim/radio_port_checker_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module radio_port_checker (
    // clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // register port and serial status
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic TX_READY,
    input wire logic SERIAL_DONE,
    input wire logic SERIAL_DONE_CLR,
    // transmitter and port lines
    input wire logic RADIO_POWER_ON,
    input wire logic RADIO_CE,
    input wire logic RADIO_CS,
    input wire logic RADIO_SHIFT_CLK,
    input wire logic RADIO_DATA,
    input wire logic [2:0] RADIO_MODE,
    input wire logic BURST_START,
    input wire logic P1_SCK,
    input wire logic P1_SDO
);
    logic [1:0] route;
    logic [1:0] route_d;
    logic [1:0] div;
    logic [2:0] pend;
    logic done_d;
    logic ctrl_wr;
    logic data_wr;
    logic [2:0] mode;
    assign ctrl_wr = SFR_WR && SFR_ADDR == radio_pkg::CTRL_ADDR;
    assign data_wr = SFR_WR && SFR_ADDR == radio_pkg::DATA_ADDR;
    // shadow copies, since route and divider are not visible at the ports
    always_ff @(posedge MCLK) begin
        if (RST) begin
            route <= 2'h0;
            route_d <= 2'h0;
            div <= 2'h0;
            pend <= 3'h0;
            done_d <= 1'b0;
        end else begin
            if (SFR_WR && SFR_ADDR == radio_pkg::ROUTE_ADDR) route <= SFR_WDATA[1:0];
            if (SFR_WR && SFR_ADDR == radio_pkg::DIV_ADDR) div <= SFR_WDATA[1:0];
            route_d <= route;
            done_d <= SERIAL_DONE;
            pend <= pend + {2'h0, data_wr && TX_READY} - {2'h0, SERIAL_DONE && !done_d};
        end
    end
    always_comb begin
        if (!RADIO_POWER_ON) mode = radio_pkg::MODE_POWER_DOWN;
        else if (RADIO_CE && RADIO_CS) mode = radio_pkg::MODE_ILLEGAL;
        else if (RADIO_CE) mode = radio_pkg::MODE_ACTIVE;
        else if (RADIO_CS) mode = radio_pkg::MODE_CONFIG;
        else mode = radio_pkg::MODE_STANDBY;
    end
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);
    sequence s_burst_end;
        ctrl_wr && RADIO_CE && SFR_WDATA[7] && !SFR_WDATA[6] && !SFR_WDATA[3];
    endsequence
    // only a start with nothing queued has a fixed latency
    sequence s_lone_start;
        data_wr && TX_READY && pend == 3'h0 && !SERIAL_DONE && route != 2'h0 && div == 2'h0;
    endsequence
    AST_RESET_DEFAULTS: assert property (disable iff (1'b0) RST |=>
        RADIO_POWER_ON && !RADIO_CE && !RADIO_CS && !BURST_START)
        else $error("reset defaults not forced");
    AST_CTRL_WRITE: assert property (ctrl_wr && !route[1] |=>
        {RADIO_POWER_ON, RADIO_CE, RADIO_CS, RADIO_SHIFT_CLK, RADIO_DATA} ==
        $past({SFR_WDATA[7], SFR_WDATA[6], SFR_WDATA[3], SFR_WDATA[1], SFR_WDATA[0]}))
        else $error("direct lines differ from written port");
    AST_LINES_HOLD: assert property (!ctrl_wr |=>
        $stable({RADIO_POWER_ON, RADIO_CE, RADIO_CS}))
        else $error("control lines moved without a write");
    AST_MODE: assert property (RADIO_MODE == mode)
        else $error("mode decode wrong");
    AST_BURST_START: assert property (s_burst_end |=> BURST_START)
        else $error("no burst start after enable fell");
    AST_BURST_PULSE: assert property (BURST_START |=> !BURST_START)
        else $error("burst start longer than one cycle");
    AST_P1_OFF: assert property (route != 2'h1 && route_d != 2'h1 |-> !P1_SCK && !P1_SDO)
        else $error("port pins driven outside port route");
    AST_DONE_HOLD: assert property (SERIAL_DONE && !SERIAL_DONE_CLR |=> SERIAL_DONE)
        else $error("done flag dropped without clear");
    AST_DONE_TIME: assert property (s_lone_start |-> ##[70:90] $rose(SERIAL_DONE))
        else $error("serial byte time wrong");
endmodule : radio_port_checker
bind radio_control_port radio_port_checker u_chk (
    .MCLK(MCLK),
    .RST(RST),
    .SFR_ADDR(SFR_ADDR),
    .SFR_WR(SFR_WR),
    .SFR_WDATA(SFR_WDATA),
    .TX_READY(TX_READY),
    .SERIAL_DONE(SERIAL_DONE),
    .SERIAL_DONE_CLR(SERIAL_DONE_CLR),
    .RADIO_POWER_ON(RADIO_POWER_ON),
    .RADIO_CE(RADIO_CE),
    .RADIO_CS(RADIO_CS),
    .RADIO_SHIFT_CLK(RADIO_SHIFT_CLK),
    .RADIO_DATA(RADIO_DATA),
    .RADIO_MODE(RADIO_MODE),
    .BURST_START(BURST_START),
    .P1_SCK(P1_SCK),
    .P1_SDO(P1_SDO)
);
`default_nettype wire

/* sim/radio_tx_model.sv */
`timescale 1ns/10ps
`default_nettype none
module radio_tx_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // transmitter control lines
    input wire logic ce,
    input wire logic cs,
    input wire logic shift_clk,
    input wire logic data,
    // what was loaded
    output logic [7:0] load,
    output logic [4:0] nbits
);
    logic clk_d;
    always_ff @(posedge clk) begin
        clk_d <= shift_clk;
        if (rst) begin
            load <= 8'h00;
            nbits <= 5'h00;
        end else if ((ce || cs) && shift_clk && !clk_d) begin
            load <= {load[6:0], data};
            nbits <= nbits + 5'h01;
        end
    end
endmodule : radio_tx_model
`default_nettype wire

/* sim/radio_control_port_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module radio_control_port_tb;
    logic MCLK = 1'b0;
    logic RST = 1'b1;
    logic [7:0] SFR_ADDR = 8'h00;
    logic SFR_WR = 1'b0;
    logic SFR_RD = 1'b0;
    logic [7:0] SFR_WDATA = 8'h00;
    logic SERIAL_DONE_CLR = 1'b0;
    logic P1_SDI = 1'b0;
    logic [7:0] SFR_RDATA;
    logic SERIAL_DONE, TX_READY, RADIO_POWER_ON, RADIO_CE, RADIO_CS, RADIO_SHIFT_CLK, RADIO_DATA;
    logic [2:0] RADIO_MODE;
    logic BURST_START, P1_SCK, P1_SDO;
    logic [7:0] load;
    logic [4:0] nbits;
    logic [7:0] rdv;
    logic [7:0] sent [4];
    logic [7:0] vals [5] = '{8'hc0, 8'h8b, 8'h80, 8'h7f, 8'hc8};
    logic [2:0] modes [5] = '{radio_pkg::MODE_ACTIVE, radio_pkg::MODE_CONFIG,
        radio_pkg::MODE_STANDBY, radio_pkg::MODE_POWER_DOWN, radio_pkg::MODE_ILLEGAL};
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;
    always #2.5 MCLK = ~MCLK;
    // loopback of the port serial pins
    // sampled after the edge, once the registered pin has settled
    always @(posedge MCLK) #1 P1_SDI = P1_SDO;
    radio_control_port u_dut (
        .MCLK(MCLK),
        .RST(RST),
        .SFR_ADDR(SFR_ADDR),
        .SFR_WR(SFR_WR),
        .SFR_RD(SFR_RD),
        .SFR_WDATA(SFR_WDATA),
        .SFR_RDATA(SFR_RDATA),
        .SERIAL_DONE(SERIAL_DONE),
        .SERIAL_DONE_CLR(SERIAL_DONE_CLR),
        .TX_READY(TX_READY),
        .RADIO_POWER_ON(RADIO_POWER_ON),
        .RADIO_CE(RADIO_CE),
        .RADIO_CS(RADIO_CS),
        .RADIO_SHIFT_CLK(RADIO_SHIFT_CLK),
        .RADIO_DATA(RADIO_DATA),
        .RADIO_MODE(RADIO_MODE),
        .BURST_START(BURST_START),
        .P1_SCK(P1_SCK),
        .P1_SDO(P1_SDO),
        .P1_SDI(P1_SDI)
    );
    radio_tx_model u_tx (.clk(MCLK), .rst(RST), .ce(RADIO_CE), .cs(RADIO_CS),
        .shift_clk(RADIO_SHIFT_CLK), .data(RADIO_DATA), .load(load), .nbits(nbits));
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    function automatic logic [7:0] lines();
        return {3'h0, RADIO_POWER_ON, RADIO_CE, RADIO_CS, RADIO_SHIFT_CLK, RADIO_DATA};
    endfunction : lines
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge MCLK) #1;
        SFR_ADDR = a;
        SFR_WDATA = d;
        SFR_WR = 1'b1;
        @(posedge MCLK) #1;
        SFR_WR = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge MCLK) #1;
        SFR_ADDR = a;
        SFR_RD = 1'b1;
        @(posedge MCLK) #1;
        SFR_RD = 1'b0;
        d = SFR_RDATA;
    endtask : rd
    // reads the received byte before clearing, as the next byte may overwrite it
    task automatic wait_done(output logic [7:0] rx);
        int n;
        n = 0;
        while (SERIAL_DONE !== 1'b1 && n < 3000) begin
            @(posedge MCLK) #1;
            n++;
        end
        check("serial_done", {7'h00, SERIAL_DONE}, 8'h01);
        rd(radio_pkg::DATA_ADDR, rx);
        @(posedge MCLK) #1;
        SERIAL_DONE_CLR = 1'b1;
        @(posedge MCLK) #1;
        SERIAL_DONE_CLR = 1'b0;
        check("done_clear", {7'h00, SERIAL_DONE}, 8'h00);
    endtask : wait_done
    task automatic t_reset();
        RST = 1'b1;
        repeat (2) @(posedge MCLK);
        #1;
        check("lines_in_reset", lines(), 8'h10);
        RST = 1'b0;
        repeat (3) @(posedge MCLK);
        #1;
        check("lines_after_reset", lines(), 8'h10);
        check("reset_mode", {5'h00, RADIO_MODE}, {5'h00, radio_pkg::MODE_STANDBY});
        rd(radio_pkg::CTRL_ADDR, rdv);
        check("ctrl_read", rdv, radio_pkg::READ_FILL);
        rd(radio_pkg::ROUTE_ADDR, rdv);
        check("route_reset", rdv, 8'h00);
        rd(8'h55, rdv);
        check("unmapped_read", rdv, 8'h00);
    endtask : t_reset
    task automatic t_direct();
        logic [7:0] d;
        for (int i = 0; i < 5; i++) begin
            d = vals[i];
            wr(radio_pkg::CTRL_ADDR, d);
            check("direct_lines", lines(), {3'h0, d[7], d[6], d[3], d[1], d[0]});
            check("direct_mode", {5'h00, RADIO_MODE}, {5'h00, modes[i]});
        end
        wr(8'h55, 8'h00);
        check("unmapped_write", lines(), {3'h0, d[7], d[6], d[3], d[1], d[0]});
    endtask : t_direct
    task automatic t_burst();
        wr(radio_pkg::ROUTE_ADDR, 8'h02);
        rd(radio_pkg::ROUTE_ADDR, rdv);
        check("route_read", rdv, 8'h02);
        wr(radio_pkg::CTRL_ADDR, 8'hc0);
        wr(radio_pkg::DATA_ADDR, 8'ha5);
        wait_done(rdv);
        check("burst_bits", {3'h0, nbits}, 8'h08);
        check("burst_load", load, 8'ha5);
        check("burst_rx", rdv, 8'h00);
        wr(radio_pkg::CTRL_ADDR, 8'h80);
        check("burst_start", {7'h00, BURST_START}, 8'h01);
        @(posedge MCLK) #1;
        check("burst_pulse", {7'h00, BURST_START}, 8'h00);
    endtask : t_burst
    task automatic t_config();
        wr(radio_pkg::DIV_ADDR, 8'h03);
        wr(radio_pkg::CTRL_ADDR, 8'h88);
        check("config_mode", {5'h00, RADIO_MODE}, {5'h00, radio_pkg::MODE_CONFIG});
        wr(radio_pkg::DATA_ADDR, 8'h3b);
        wait_done(rdv);
        check("config_bits", {3'h0, nbits}, 8'h10);
        check("config_load", load, 8'h3b);
        check("config_rx", rdv, 8'h00);
        wr(radio_pkg::CTRL_ADDR, 8'h80);
        check("config_no_burst", {7'h00, BURST_START}, 8'h00);
    endtask : t_config
    task automatic t_buffer();
        int n;
        wr(radio_pkg::ROUTE_ADDR, 8'h01);
        wr(radio_pkg::DIV_ADDR, 8'h01);
        rd(radio_pkg::DIV_ADDR, rdv);
        check("div_read", rdv, 8'h01);
        n = 0;
        // the first byte keeps the engine busy, so the queue fills and refuses
        while (TX_READY === 1'b1 && n < 4) begin
            sent[n] = 8'(8'h3c + 8'h47 * n);
            wr(radio_pkg::DATA_ADDR, sent[n]);
            n++;
        end
        check("buffer_full", {7'h00, TX_READY}, 8'h00);
        wr(radio_pkg::DATA_ADDR, 8'hee);
        for (int i = 0; i < n; i++) begin
            wait_done(rdv);
            check("loop_rx", rdv, sent[i]);
        end
        repeat (300) @(posedge MCLK);
        #1;
        check("dropped_byte", {7'h00, SERIAL_DONE}, 8'h00);
        check("buffer_empty", {7'h00, TX_READY}, 8'h01);
    endtask : t_buffer
    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            final_report();
        end
    end
    initial begin
        t_reset();
        t_direct();
        t_reset();
        t_burst();
        t_config();
        t_buffer();
        final_report();
    end
endmodule : radio_control_port_tb
`default_nettype wire
